// ### rtl/ots_pkg.sv
// overtravel stop sequencer: register map, field layout, codes and carrier types
// assumes a 32-bit apb master and a 100 MHz control clock
package ots_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_NET_EXT   = 8'h04;
  localparam logic [7:0] ADDR_ESTOP_TRQ = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h14;

  // control register fields, and the net_ext command error report bit
  localparam int CTRL_SETUP_LSB = 0;  // limit_input_setup, 2 bits
  localparam int CTRL_SEQ_LSB   = 2;  // limit_stop_sequence, 2 bits
  localparam int CTRL_ALARM_LSB = 4;  // alarm_stop_sequence, 3 bits
  localparam int CTRL_CLR_BIT   = 7;  // write one: leave alarm stop
  localparam int NET_ERR_BIT    = 9;  // command error report enable

  // status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_POS_BIT   = 2;
  localparam int STAT_NEG_BIT   = 3;
  localparam int STAT_PROT_BIT  = 4;

  // interrupt event bits
  localparam int IRQ_W         = 4;
  localparam int EV_LIMIT      = 0;
  localparam int EV_STOPPED    = 1;
  localparam int EV_CMD_ERR    = 2;
  localparam int EV_PROT       = 3;

  // reset values
  localparam logic [1:0]  RST_SETUP     = 2'h0;
  localparam logic [1:0]  RST_SEQ       = 2'h0;
  localparam logic [2:0]  RST_ALARM_SEQ = 3'h0;
  localparam logic [15:0] RST_NET_EXT   = 16'h0000;
  localparam logic [15:0] RST_ESTOP_TRQ = 16'h0000;

  // setting codes
  localparam logic [1:0] SETUP_SEQ  = 2'h0;  // limit-stop sequence active
  localparam logic [1:0] SETUP_PROT = 2'h2;  // limit input raises protection error
  localparam logic [1:0] SEQ_DB     = 2'h0;  // dynamic braking
  localparam logic [1:0] SEQ_FREE   = 2'h1;  // free run, braking off
  localparam logic [1:0] SEQ_ESTOP  = 2'h2;  // emergency stop

  // stop threshold, speed input in r/min
  localparam logic signed [15:0] STOP_RPM = 16'sh001e;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {ST_RUN, ST_DECEL, ST_STOPPED, ST_ALARM} ots_state_type;

  // host motion command
  typedef struct packed {
    logic valid;
    logic dir_neg;  // 1: toward negative travel
  } ots_cmd_type;

  // answer to a host command, one-cycle pulses
  typedef struct packed {
    logic accept;
    logic ignored;
    logic error;
  } ots_resp_type;

  // commands to the servo core
  typedef struct packed {
    logic force_pos;
    logic halt_gen;
    logic dyn_brake;
    logic free_run;
    logic estop;
    logic dev_clear;
    logic dev_hold;
    logic alarm_stop;
    logic prot_err;
  } ots_drive_type;

  // whole state of the sequencer
  typedef struct packed {
    ots_state_type        state;
    logic [2:0]           pos_sync;
    logic [2:0]           neg_sync;
    logic                 pos_lim;
    logic                 neg_lim;
    logic                 prot;
    logic [1:0]           setup;
    logic [1:0]           seq;
    logic [2:0]           alarm_seq;
    logic [15:0]          net_ext;
    logic [15:0]          estop_trq;
    logic [IRQ_W-1:0]     irq_stat;
    logic [IRQ_W-1:0]     irq_mask;
    logic                 apb_rdy;
    logic [31:0]          prdata;
    logic signed [15:0]   trq;
    logic signed [31:0]   cmd_pos;
    ots_drive_type        drive;
    ots_resp_type         resp;
  } ots_regs_type;

endpackage

// ### rtl/ots_sequencer.sv
// overtravel stop sequencer: limit-input stop handling with apb registers
// assumes limit pins are asynchronous, all other inputs on sys_clk_i
//
// Behaviour
// (R1) limit-stop sequence runs only while limit_input_setup is 0
// (R2) during deceleration force position control and halt command generation
// (R3) limit_stop_sequence 0 dynamic braking, 1 free run, 2 emergency stop
// (R4) after stop, ignore commands toward the inhibited direction
// (R5) with network_ext_setup_2 bit 9 set, ignored commands return an error
// (R6) while clearing deviation, command position follows feedback position
// (R7) deviation from deceleration is cleared at stop and end of deceleration
// (R8) setup 2: limit input raises protection error, alarm stop sequence used
// (R9) any other error gives the alarm stop sequence precedence
// (R10) emergency stop halts under control with servo kept energised
// (R11) during emergency stop torque is clamped to emergency_stop_torque
// (R12) deceleration ends below 30 r/min, motor then treated as stopped
// (R13) after stop with sequence 0 or 1, zero inhibited torque, hold deviation
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module ots_sequencer
  import ots_pkg::*;
(
  input  wire logic                sys_clk_i,
  input  wire logic                arst_n_i,
  input  wire logic                ce_i,
  // apb slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic                     pready_o,
  output logic                     pslverr_o,
  output logic [31:0]              prdata_o,
  // limit pins and drive state
  input  wire logic                positive_limit_input_i,
  input  wire logic                negative_limit_input_i,
  input  wire logic                other_error_i,
  input  wire logic signed [15:0]  motor_speed_i,
  input  wire logic signed [15:0]  torque_cmd_i,
  input  wire logic signed [31:0]  cmd_pos_i,
  input  wire logic signed [31:0]  fb_pos_i,
  // host command and answer
  input  wire ots_cmd_type         host_cmd_i,
  output ots_resp_type             host_resp_o,
  // servo core controls
  output ots_drive_type            drive_o,
  output logic [2:0]               alarm_stop_sequence_o,
  output logic signed [15:0]       torque_cmd_o,
  output logic signed [31:0]       cmd_pos_o,
  output logic                     irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state and helpers
  ots_regs_type st;
  ots_regs_type next_st;

  logic        apb_done;
  logic        wr_en;
  logic        mapped;
  logic        speed_low;
  logic        any_lim;
  logic        toward_inh;
  logic        alarm_clr;
  logic [31:0] rd_val;

  // a transfer completes only on an edge where the state may move
  assign apb_done  = ce_i && psel_i && penable_i && st.apb_rdy;
  assign wr_en     = apb_done && pwrite_i;
  assign alarm_clr = wr_en && (paddr_i == ADDR_CTRL) && pwdata_i[CTRL_CLR_BIT];

  // stop threshold on both directions of rotation
  assign speed_low = (motor_speed_i < STOP_RPM) && (motor_speed_i > -STOP_RPM); // R12
  assign any_lim   = st.pos_lim || st.neg_lim;
  assign toward_inh = host_cmd_i.dir_neg ? st.neg_lim : st.pos_lim;

  // address decode and read mux
  always_comb
  begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr_i)
      ADDR_CTRL:
      begin
        rd_val[CTRL_SETUP_LSB +: 2] = st.setup;
        rd_val[CTRL_SEQ_LSB +: 2]   = st.seq;
        rd_val[CTRL_ALARM_LSB +: 3] = st.alarm_seq;
      end
      ADDR_NET_EXT:   rd_val[15:0] = st.net_ext;
      ADDR_ESTOP_TRQ: rd_val[15:0] = st.estop_trq;
      ADDR_STATUS:
      begin
        rd_val[STAT_STATE_LSB +: 2] = st.state;
        rd_val[STAT_POS_BIT]        = st.pos_lim;
        rd_val[STAT_NEG_BIT]        = st.neg_lim;
        rd_val[STAT_PROT_BIT]       = st.prot;
      end
      ADDR_IRQ_STAT:  rd_val[IRQ_W-1:0] = st.irq_stat;
      ADDR_IRQ_MASK:  rd_val[IRQ_W-1:0] = st.irq_mask;
      default:        mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] w1c;
    logic             blocked;
    logic             to_stop;
    ev      = '0;
    w1c     = '0;
    blocked = 1'b0;
    to_stop = 1'b0;
    next_st = st;

    // limit pins: third stage only shadows the second; a change counts when they agree
    next_st.pos_sync = {st.pos_sync[1:0], positive_limit_input_i};
    next_st.neg_sync = {st.neg_sync[1:0], negative_limit_input_i};
    if (st.pos_sync[1] == st.pos_sync[2])
      next_st.pos_lim = st.pos_sync[2];
    if (st.neg_sync[1] == st.neg_sync[2])
      next_st.neg_lim = st.neg_sync[2];

    // apb: capture read data a cycle early so prdata comes from flops
    if (psel_i && !st.apb_rdy)
    begin
      next_st.apb_rdy = 1'b1;
      next_st.prdata  = rd_val;
    end
    if (apb_done)
      next_st.apb_rdy = 1'b0;

    // register writes take effect at the completing edge only
    if (wr_en)
    begin
      unique case (paddr_i)
        ADDR_CTRL:
        begin
          next_st.setup     = pwdata_i[CTRL_SETUP_LSB +: 2];
          next_st.seq       = pwdata_i[CTRL_SEQ_LSB +: 2];
          next_st.alarm_seq = pwdata_i[CTRL_ALARM_LSB +: 3];
        end
        ADDR_NET_EXT:   next_st.net_ext   = pwdata_i[15:0];
        ADDR_ESTOP_TRQ: next_st.estop_trq = pwdata_i[15:0];
        ADDR_IRQ_STAT:  w1c               = pwdata_i[IRQ_W-1:0];
        ADDR_IRQ_MASK:  next_st.irq_mask  = pwdata_i[IRQ_W-1:0];
        default:        ;
      endcase
    end

    // sequencer; other errors always win
    unique case (st.state)
      ST_RUN:
      begin
        if (other_error_i)
          next_st.state = ST_ALARM; // R9
        else if (any_lim && st.setup == SETUP_SEQ)
        begin
          next_st.state   = ST_DECEL; // R1
          ev[EV_LIMIT]    = 1'b1;
        end
        else if (any_lim && st.setup == SETUP_PROT)
        begin
          next_st.state   = ST_ALARM; // R8
          next_st.prot    = 1'b1;
          ev[EV_PROT]     = 1'b1;
        end
      end
      ST_DECEL:
      begin
        if (other_error_i)
          next_st.state = ST_ALARM; // R9
        else if (speed_low)
        begin
          next_st.state  = ST_STOPPED; // R12
          to_stop        = 1'b1;
          ev[EV_STOPPED] = 1'b1;
        end
      end
      ST_STOPPED:
      begin
        if (other_error_i)
          next_st.state = ST_ALARM; // R9
        else if (!any_lim)
          next_st.state = ST_RUN;
      end
      ST_ALARM:
      begin
        // leaving needs software, a clear cause and no pending protection trip
        if (alarm_clr && !other_error_i && !(any_lim && st.setup == SETUP_PROT))
        begin
          next_st.state = ST_RUN;
          next_st.prot  = 1'b0;
        end
      end
    endcase

    // host commands: halted while decelerating or in alarm
    next_st.resp = '0;
    if (host_cmd_i.valid)
    begin
      blocked = (st.state == ST_DECEL) || (st.state == ST_ALARM) ||
                ((st.state == ST_STOPPED) && toward_inh); // R4
      next_st.resp.accept  = !blocked;
      next_st.resp.ignored = blocked;
      if ((st.state == ST_STOPPED) && toward_inh && st.net_ext[NET_ERR_BIT])
      begin
        next_st.resp.error = 1'b1; // R5
        ev[EV_CMD_ERR]     = 1'b1;
      end
    end

    // drive controls follow the coming state so they line up with it
    next_st.drive            = '0;
    next_st.drive.force_pos  = (next_st.state == ST_DECEL); // R2
    next_st.drive.halt_gen   = (next_st.state == ST_DECEL); // R2
    next_st.drive.dyn_brake  = (next_st.state == ST_DECEL) && (next_st.seq == SEQ_DB);   // R3
    next_st.drive.free_run   = (next_st.state == ST_DECEL) && (next_st.seq == SEQ_FREE); // R3
    // estop keeps servo on: neither braking nor free run may join it
    next_st.drive.estop      = (next_st.state == ST_DECEL) && (next_st.seq == SEQ_ESTOP); // R10
    next_st.drive.dev_clear  = (next_st.state == ST_DECEL) || to_stop; // R7
    next_st.drive.dev_hold   = (next_st.state == ST_STOPPED) && !to_stop; // R13
    next_st.drive.alarm_stop = (next_st.state == ST_ALARM); // R9
    next_st.drive.prot_err   = next_st.prot; // R8

    // torque shaping
    next_st.trq = torque_cmd_i;
    if (next_st.drive.estop)
    begin
      // clamp both ways to the emergency torque magnitude
      if (torque_cmd_i > $signed(next_st.estop_trq))
        next_st.trq = $signed(next_st.estop_trq); // R11
      else if (torque_cmd_i < -$signed(next_st.estop_trq))
        next_st.trq = -$signed(next_st.estop_trq); // R11
    end
    else if ((next_st.state == ST_STOPPED) && (next_st.seq != SEQ_ESTOP))
    begin
      if ((next_st.pos_lim && torque_cmd_i > 16'sh0000) ||
          (next_st.neg_lim && torque_cmd_i < 16'sh0000))
        next_st.trq = 16'sh0000; // R13
    end

    // command position tracks feedback while deviation is cleared
    next_st.cmd_pos = next_st.drive.dev_clear ? fb_pos_i : cmd_pos_i; // R6

    // sticky events, set wins over a clearing write
    next_st.irq_stat = (st.irq_stat & ~w1c) | ev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, frozen while ce_i is low
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st           <= '0;
      st.state     <= ST_RUN;
      st.setup     <= RST_SETUP;
      st.seq       <= RST_SEQ;
      st.alarm_seq <= RST_ALARM_SEQ;
      st.net_ext   <= RST_NET_EXT;
      st.estop_trq <= RST_ESTOP_TRQ;
    end
    else if (ce_i)
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign pready_o              = ce_i && psel_i && penable_i && st.apb_rdy;
  assign pslverr_o             = pready_o && !mapped;
  assign prdata_o              = st.prdata;
  assign host_resp_o           = st.resp;
  assign drive_o               = st.drive;
  assign alarm_stop_sequence_o = st.alarm_seq;
  assign torque_cmd_o          = st.trq;
  assign cmd_pos_o             = st.cmd_pos;
  assign irq_o                 = |(st.irq_stat & st.irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_limit_in_run;
    ce_i && st.state == ST_RUN && any_lim && !other_error_i;
  endsequence

  sequence s_inhibited_cmd;
    ce_i && st.state == ST_STOPPED && host_cmd_i.valid && toward_inh;
  endsequence

  sequence s_decel_done;
    ce_i && st.state == ST_DECEL && speed_low && !other_error_i;
  endsequence

  chk_seq_gate: assert property ( // R1
    (s_limit_in_run and (st.setup != SETUP_SEQ)) |=> st.state != ST_DECEL)
    else $error("limit sequence entered with setup not zero");

  chk_decel_force: assert property ( // R2
    st.state == ST_DECEL |-> drive_o.force_pos && drive_o.halt_gen)
    else $error("deceleration without forced position control");

  chk_stop_method: assert property ( // R3
    st.state == ST_DECEL |-> (drive_o.dyn_brake == (st.seq == SEQ_DB)) &&
                            (drive_o.free_run == (st.seq == SEQ_FREE)) &&
                            (drive_o.estop == (st.seq == SEQ_ESTOP)))
    else $error("stop method does not match sequence setting");

  chk_cmd_block: assert property ( // R4
    s_inhibited_cmd |=> !host_resp_o.accept && host_resp_o.ignored)
    else $error("command toward inhibited side accepted");

  chk_cmd_error: assert property ( // R5
    s_inhibited_cmd |=> host_resp_o.error == $past(st.net_ext[NET_ERR_BIT]))
    else $error("command error report wrong");

  chk_track_fb: assert property ( // R6
    (drive_o.dev_clear && $past(ce_i)) |-> cmd_pos_o == $past(fb_pos_i))
    else $error("command position not following feedback");

  chk_stop_clear: assert property ( // R7
    s_decel_done |=> st.state == ST_STOPPED && drive_o.dev_clear ##1
                     (!$past(ce_i) || drive_o.dev_hold || st.state != ST_STOPPED))
    else $error("deviation not cleared at end of deceleration");

  chk_prot_alarm: assert property ( // R8
    (s_limit_in_run and (st.setup == SETUP_PROT)) |=>
      st.state == ST_ALARM && drive_o.prot_err && st.irq_stat[EV_PROT])
    else $error("protection error not raised");

  chk_alarm_prio: assert property ( // R9
    (ce_i && other_error_i && st.state != ST_ALARM) |=> drive_o.alarm_stop)
    else $error("other error did not start alarm stop");

  chk_estop_servo: assert property ( // R10
    drive_o.estop |-> !drive_o.free_run && !drive_o.dyn_brake && drive_o.force_pos)
    else $error("emergency stop released the servo");

  chk_estop_clamp: assert property ( // R11
    drive_o.estop |-> (torque_cmd_o <= $signed(st.estop_trq)) &&
                      (torque_cmd_o >= -$signed(st.estop_trq)))
    else $error("torque beyond emergency stop limit");

  chk_slow_stop: assert property ( // R12
    (ce_i && st.state == ST_DECEL && !speed_low && !other_error_i) |=> st.state == ST_DECEL)
    else $error("deceleration ended above threshold");

  chk_after_stop: assert property ( // R13
    (st.state == ST_STOPPED && st.seq != SEQ_ESTOP) |->
      (!st.pos_lim || torque_cmd_o <= 16'sh0000) &&
      (!st.neg_lim || torque_cmd_o >= 16'sh0000))
    else $error("torque toward inhibited side after stop");

endmodule

`default_nettype wire

// ### verif/ots_host_model.sv
// host motion controller model: issues one position command per call
// assumes the caller enters send() right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none

module ots_host_model
  import ots_pkg::*;
(
  input  wire logic      sys_clk_i,
  output var ots_cmd_type host_cmd_o
);
  // idle at time zero, no command pending
  initial host_cmd_o = '0;

  // one-cycle valid pulse; direction flips afterwards so it never looks held
  task automatic send(input logic dir_neg);
    host_cmd_o.valid   <= 1'b1;
    host_cmd_o.dir_neg <= dir_neg;
    @(posedge sys_clk_i);
    host_cmd_o.valid   <= 1'b0;
    host_cmd_o.dir_neg <= ~dir_neg;
  endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the overtravel stop sequencer
// assumes ce_i high apart from one freeze check; host commands come from the host model
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import ots_pkg::*;
  logic                sys_clk_i = 1'b0;
  logic                arst_n    = 1'b0;
  logic                psel      = 1'b0;
  logic                penable   = 1'b0;
  logic                pwrite    = 1'b0;
  logic [7:0]          paddr     = 8'h00;
  logic [31:0]         pwdata    = 32'h0;
  logic                pos_lim   = 1'b0;
  logic                neg_lim   = 1'b0;
  logic                oth_err   = 1'b0;
  logic                ce        = 1'b1;
  logic signed [15:0]  speed     = 16'sh0;
  logic signed [15:0]  trq_in    = 16'sh0;
  logic signed [31:0]  cmdp      = 32'sh0;
  logic signed [31:0]  fbp       = 32'sh0;
  logic                pready;
  logic                pslverr;
  logic [31:0]         prdata;
  ots_cmd_type         host_cmd;
  ots_resp_type        host_resp;
  ots_drive_type       drive;
  logic [2:0]          alarm_seq;
  logic signed [15:0]  trq_out;
  logic signed [31:0]  cmdp_out;
  logic                irq;
  ots_resp_type        exp_q[$];
  int                  mismatches = 0;
  int                  cmp_count  = 0;

  // free-running system clock
  always #5 sys_clk_i = ~sys_clk_i;

  ots_sequencer u_dut (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata),
    .positive_limit_input_i(pos_lim), .negative_limit_input_i(neg_lim),
    .other_error_i(oth_err), .motor_speed_i(speed), .torque_cmd_i(trq_in),
    .cmd_pos_i(cmdp), .fb_pos_i(fbp), .host_cmd_i(host_cmd), .host_resp_o(host_resp),
    .drive_o(drive), .alarm_stop_sequence_o(alarm_seq), .torque_cmd_o(trq_out),
    .cmd_pos_o(cmdp_out), .irq_o(irq)
  );

  ots_host_model u_host (.sys_clk_i(sys_clk_i), .host_cmd_o(host_cmd));

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic timeout(input string what);
    mismatches++;
    $display("BAD %s expected completion seen none", what);
    wrap_up();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // bounded wait for one drive_o flag, by bit position
  task automatic wait_on(input int b);
    for (int n = 0; n < 40; n++)
    begin
      @(posedge sys_clk_i);
      if (drive[b] === 1'b1)
        return;
    end
    timeout("drive flag");
  endtask

  // apb transfer; an idle edge follows so the next setup is a fresh assignment
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    for (int n = 0; n < 20; n++)
    begin
      @(posedge sys_clk_i);
      if (pready === 1'b1)
        break;
      if (n == 19)
        timeout("apb");
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    check(what, rd, exp);
    check("pslverr", err, 1'b0);
  endtask

  // expected answer noted first, the monitor compares it
  task automatic cmd(input logic dir_neg, input ots_resp_type exp);
    exp_q.push_back(exp);
    u_host.send(dir_neg);
    @(posedge sys_clk_i);
  endtask

  // response monitor: oldest note against every answer pulse
  always @(posedge sys_clk_i)
    if ((|host_resp) === 1'b1)
      check("host_resp", host_resp, exp_q.size() > 0 ? exp_q.pop_front() : 3'b111);

  ////////////////////////////////////////////////////////////////////////
  // limit stop with sequence seq on the positive or negative pin
  task automatic run_stop(input logic [1:0] seq, input logic neg);
    logic signed [15:0] lim;
    logic signed [15:0] t;
    logic               bit9;
    ots_drive_type      ed;
    lim = 16'($urandom_range(16'h7ff, 16'h100));
    t = 16'($urandom_range(16'h7fff, 1));
    bit9 = (seq != SEQ_FREE);
    wr(ADDR_CTRL, {28'h0, seq, SETUP_SEQ});
    wr(ADDR_NET_EXT, {22'h0, bit9, 9'h0});
    wr(ADDR_ESTOP_TRQ, {16'h0, lim});
    wr(ADDR_IRQ_MASK, 32'h0);
    speed <= 16'sd500;
    trq_in <= 16'sh4000;
    fbp <= $urandom;
    cmdp <= $urandom;
    if (neg)
      neg_lim <= 1'b1;
    else
      pos_lim <= 1'b1;
    wait_on(8);
    tick(2);
    ed = '{1'b1, 1'b1, seq == SEQ_DB, seq == SEQ_FREE, seq == SEQ_ESTOP, 1'b1, 1'b0, 1'b0, 1'b0};
    check("drive_decel", drive, ed);
    check("cmd_pos_clear", cmdp_out, fbp);
    check("torque_decel", trq_out, seq == SEQ_ESTOP ? lim : 16'sh4000);
    check("irq_masked", irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'hf);
    check("irq_unmasked", irq, 1'b1);
    trq_in <= -16'sh4000;
    tick(2);
    check("torque_decel_neg", trq_out, seq == SEQ_ESTOP ? -lim : -16'sh4000);
    cmd(neg, 3'b010);
    // exactly 30 r/min is not yet below the threshold
    speed <= neg ? -16'sd30 : 16'sd30;
    tick(4);
    check("decel_at_30", drive.force_pos, 1'b1);
    speed <= neg ? -16'sd29 : 16'sd29;
    wait_on(2);
    check("stop_method", {drive.dyn_brake, drive.free_run, drive.estop}, 3'b0);
    rd_chk("status_stop", ADDR_STATUS, neg ? 32'ha : 32'h6);
    cmdp <= $urandom;
    trq_in <= neg ? -t : t;
    tick(2);
    check("cmd_pos_hold", cmdp_out, cmdp);
    check("torque_inhib", trq_out, seq == SEQ_ESTOP ? (neg ? -t : t) : 16'sh0);
    trq_in <= neg ? t : -t;
    tick(2);
    check("torque_open", trq_out, neg ? t : -t);
    cmd(neg, {1'b0, 1'b1, bit9});
    cmd(~neg, 3'b100);
    rd_chk("irq_stat", ADDR_IRQ_STAT, bit9 ? 32'h7 : 32'h3);
    wr(ADDR_IRQ_STAT, 32'hf);
    check("irq_cleared", irq, 1'b0);
    pos_lim <= 1'b0;
    neg_lim <= 1'b0;
    speed <= 16'sh0;
    tick(6);
    rd_chk("status_run", ADDR_STATUS, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    logic [31:0] rdv;
    logic        err;
    logic [2:0]  a;
    void'($urandom(57057));
    tick(5);
    arst_n <= 1'b1;
    // reset values, read-only status, unmapped place, unused upper bits
    for (int i = 0; i < 6; i++)
      rd_chk("reset_value", 8'(4 * i), 32'h0);
    wr(ADDR_STATUS, 32'hffffffff);
    rd_chk("status_ro", ADDR_STATUS, 32'h0);
    apb(1'b0, 8'h18, 32'h0, rdv, err);
    check("unmapped_err", err, 1'b1);
    check("unmapped_data", rdv, 32'h0);
    wr(ADDR_NET_EXT, 32'hffffffff);
    rd_chk("net_ext_width", ADDR_NET_EXT, 32'h0000ffff);
    run_stop(SEQ_DB, 1'b0);
    run_stop(SEQ_FREE, 1'b1);
    run_stop(SEQ_ESTOP, 1'b0);
    // setup 1: limit seen but no stop sequence
    wr(ADDR_CTRL, 32'h1);
    pos_lim <= 1'b1;
    tick(8);
    check("setup1_idle", drive, 9'h0);
    rd_chk("status_setup1", ADDR_STATUS, 32'h4);
    // setup 2: protection error, alarm stop instead of limit stop
    wr(ADDR_CTRL, {28'h0, SEQ_DB, SETUP_PROT});
    wait_on(0);
    check("prot_alarm", {drive.alarm_stop, drive.dyn_brake}, 2'b10);
    rd_chk("status_prot", ADDR_STATUS, 32'h17);
    rd_chk("irq_prot", ADDR_IRQ_STAT, 32'h8);
    check("irq_prot_line", irq, 1'b1);
    pos_lim <= 1'b0;
    tick(6);
    wr(ADDR_CTRL, 32'h80);
    rd_chk("status_prot_clr", ADDR_STATUS, 32'h0);
    // other error takes the alarm stop sequence
    a = 3'($urandom_range(7, 0));
    wr(ADDR_CTRL, {25'h0, a, 4'h0});
    // clock enable low freezes the sequencer, the error waits for it
    ce <= 1'b0;
    oth_err <= 1'b1;
    tick(4);
    check("ce_freeze", drive.alarm_stop, 1'b0);
    ce <= 1'b1;
    wait_on(1);
    check("alarm_seq", alarm_seq, a);
    cmd(1'b0, 3'b010);
    oth_err <= 1'b0;
    tick(1);
    wr(ADDR_CTRL, 32'h80);
    rd_chk("status_alarm_clr", ADDR_STATUS, 32'h0);
    tick(3);
    check("resp_left", exp_q.size(), 32'h0);
    // reset in mid-run returns registers to their reset values
    wr(ADDR_ESTOP_TRQ, 32'h1234);
    arst_n <= 1'b0;
    tick(2);
    arst_n <= 1'b1;
    rd_chk("reset_mid", ADDR_ESTOP_TRQ, 32'h0);
    rd_chk("reset_mid_mask", ADDR_IRQ_MASK, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
